// File: rars_cfg.svh
// Timing constants and memory layout for the start-up sequencer
`ifndef RARS_CFG_SVH
`define RARS_CFG_SVH
`define RARS_SCLK_NS 25
`define RARS_SETTLE_CYC 12
`define RARS_PULSE_MIN 2
`define RARS_PULSE_MAX 5
`define RARS_RESET_MIN 2
`define RARS_CNT_W 4
`define RARS_ADDR_W 8
`define RARS_DATA_W 32
`define RARS_HOLD_BIT 30
`define RARS_CB_ADDR 8'h00
`define RARS_CB_WORDS 4'h4
`define RARS_NEXT_OFS 8'h02
`define RARS_POLL_GAP 4'h8
`endif

// File: rars_pkg.sv
// Types shared by both ends of the start-up sequencer
package rars_pkg;
  typedef enum {
    RARS_DEV_RESET, RARS_DEV_SETTLE, RARS_DEV_IDLE, RARS_DEV_INIT,
    RARS_DEV_DESC, RARS_DEV_SEND, RARS_DEV_POLL, RARS_DEV_GAP
  } rars_dev_state_type;
  typedef enum {
    RARS_HOST_WAIT, RARS_HOST_PULSE, RARS_HOST_READY, RARS_HOST_LINK,
    RARS_HOST_CLEAR
  } rars_host_state_type;
endpackage : rars_pkg

// File: rars_if.sv
// Interface joining host and device of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
interface rars_if;
  logic host_attention_pulse_n;
  logic bus_oe;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic mem_ack;
  modport device (input host_attention_pulse_n, output bus_oe, mem_rd,
    output mem_addr, input mem_rdata, mem_ack);
  modport host (output host_attention_pulse_n, input bus_oe, mem_rd,
    input mem_addr, output mem_rdata, mem_ack, mem_wr, mem_wdata);
endinterface : rars_if
`default_nettype wire

// File: rars_device.sv
// Device end: reset sequence, init fetch, descriptor hold polling
// Behaviour
// - Bus tristated and sequencer held in its reset state during reset
// - Reset release starts twelve-cycle final phase
// - Host waits twelve cycles before request
// - Request pulse lasts two to five cycles
// - Reset held at least two cycles
// - Request triggers init fetch then transmission
// - Poll last descriptor hold until cleared
// - Host links descriptor then clears hold
`timescale 1ns/1ps
`default_nettype none
`include "rars_cfg.svh"
module rars_device (
  input wire logic clock_i,
  input wire logic reset_i,
  rars_if.device link,
  output logic ready_o,
  output logic frame_start_o,
  output logic [31:0] frame_desc_o,
  output logic bad_pulse_o
);
  import rars_pkg::*;
  // ********************
  // Request sampling
  // ********************
  // Same clock as host, so no synchroniser
  logic [`RARS_CNT_W-1:0] width, next_width;
  logic req_prev, next_req_prev;
  logic req_seen, bad;
  always_comb begin
    next_req_prev = !link.host_attention_pulse_n;
    next_width = width;
    req_seen = 1'b0;
    bad = 1'b0;
    if (!link.host_attention_pulse_n) begin
      if (width != {`RARS_CNT_W{1'b1}}) next_width = width + 1'b1;
    end else begin
      next_width = '0;
      if (req_prev) begin
        // Pulse judged at its end, so a wrong width can be rejected
        if (width >= `RARS_PULSE_MIN && width <= `RARS_PULSE_MAX) begin
          req_seen = 1'b1;
        end else begin
          bad = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      width <= '0;
      req_prev <= 1'b0;
    end else begin
      width <= next_width;
      req_prev <= next_req_prev;
    end
  end
  // ********************
  // Sequencer
  // ********************
  rars_dev_state_type state, next_state;
  logic [`RARS_CNT_W-1:0] cnt, next_cnt;
  logic [7:0] addr, next_addr;
  logic [7:0] last, next_last;
  logic [31:0] desc, next_desc;
  logic start, next_start, next_bad;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = addr;
    next_last = last;
    next_desc = desc;
    next_start = 1'b0;
    next_bad = bad && state != RARS_DEV_IDLE ? 1'b1 : 1'b0;
    unique case (state)
      RARS_DEV_RESET: begin
        next_state = RARS_DEV_SETTLE;
        next_cnt = '0;
      end
      RARS_DEV_SETTLE: begin
        next_cnt = cnt + 1'b1;
        if (cnt == `RARS_CNT_W'(`RARS_SETTLE_CYC - 1)) begin
          next_state = RARS_DEV_IDLE;
        end
      end
      RARS_DEV_IDLE: begin
        next_bad = bad;
        if (req_seen) begin
          next_state = RARS_DEV_INIT;
          next_addr = `RARS_CB_ADDR;
          next_cnt = '0;
        end
      end
      RARS_DEV_INIT: begin
        if (link.mem_ack) begin
          next_cnt = cnt + 1'b1;
          next_addr = addr + 8'h01;
          if (cnt == `RARS_CB_WORDS - 4'h1) begin
            // Last control word points at first descriptor
            next_addr = link.mem_rdata[7:0];
            next_state = RARS_DEV_DESC;
          end
        end
      end
      RARS_DEV_DESC: begin
        if (link.mem_ack) begin
          next_desc = link.mem_rdata;
          next_last = addr;
          if (link.mem_rdata[`RARS_HOLD_BIT]) begin
            next_state = RARS_DEV_GAP;
            next_cnt = '0;
          end else begin
            next_state = RARS_DEV_SEND;
            next_start = 1'b1;
            next_addr = addr + `RARS_NEXT_OFS;
          end
        end
      end
      RARS_DEV_SEND: begin
        // Fetch next pointer; frame payload handled downstream
        if (link.mem_ack) begin
          next_addr = link.mem_rdata[7:0];
          next_state = RARS_DEV_DESC;
        end
      end
      RARS_DEV_GAP: begin
        // Spacing polls leaves the memory free for the host
        next_cnt = cnt + 1'b1;
        if (cnt == `RARS_POLL_GAP) begin
          next_state = RARS_DEV_POLL;
          next_addr = last;
        end
      end
      RARS_DEV_POLL: begin
        next_state = RARS_DEV_DESC;
      end
    endcase
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= RARS_DEV_RESET;
      cnt <= '0;
      addr <= '0;
      last <= '0;
      desc <= '0;
      frame_start_o <= 1'b0;
      bad_pulse_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      addr <= next_addr;
      last <= next_last;
      desc <= next_desc;
      frame_start_o <= next_start;
      bad_pulse_o <= next_bad;
    end
  end
  assign frame_desc_o = desc;
  assign ready_o = state == RARS_DEV_IDLE;
  // Bus stays released through reset, settle and idle, until a request starts the init fetch
  assign link.bus_oe = !reset_i && state != RARS_DEV_RESET
    && state != RARS_DEV_SETTLE && state != RARS_DEV_IDLE;
  assign link.mem_rd = state == RARS_DEV_INIT || state == RARS_DEV_DESC
    || state == RARS_DEV_SEND;
  assign link.mem_addr = addr;
  // is the system's duty; one edge of reset suffices here
endmodule : rars_device
`default_nettype wire

// File: rars_host.sv
// Host end: post-reset wait, request pulse, frame release
`timescale 1ns/1ps
`default_nettype none
`include "rars_cfg.svh"
module rars_host (
  input wire logic clock_i,
  input wire logic reset_i,
  rars_if.host link,
  input wire logic start_i,
  input wire logic [`RARS_CNT_W-1:0] pulse_len_i,
  input wire logic release_i,
  input wire logic [7:0] last_addr_i,
  input wire logic [7:0] new_addr_i,
  input wire logic [31:0] last_word_i,
  output logic busy_o,
  output logic done_o
);
  import rars_pkg::*;
  // ********************
  // Sequencer
  // ********************
  rars_host_state_type state, next_state;
  logic [`RARS_CNT_W-1:0] cnt, next_cnt, len;
  logic pulse_n, next_pulse_n, done, next_done;
  always_comb begin
    // Requested length clamped into the legal window
    len = pulse_len_i < `RARS_PULSE_MIN ? `RARS_CNT_W'(`RARS_PULSE_MIN)
      : pulse_len_i > `RARS_PULSE_MAX ? `RARS_CNT_W'(`RARS_PULSE_MAX)
      : pulse_len_i;
    next_state = state;
    next_cnt = cnt;
    next_pulse_n = 1'b1;
    next_done = 1'b0;
    unique case (state)
      RARS_HOST_WAIT: begin
        if (cnt != `RARS_CNT_W'(`RARS_SETTLE_CYC)) next_cnt = cnt + 1'b1;
        if (cnt == `RARS_CNT_W'(`RARS_SETTLE_CYC) && start_i) begin
          next_state = RARS_HOST_PULSE;
          next_pulse_n = 1'b0;
          next_cnt = `RARS_CNT_W'(1);
        end
      end
      RARS_HOST_PULSE: begin
        if (cnt == len) begin
          next_state = RARS_HOST_READY;
        end else begin
          next_pulse_n = 1'b0;
          next_cnt = cnt + 1'b1;
        end
      end
      RARS_HOST_READY: begin
        if (release_i) next_state = RARS_HOST_LINK;
      end
      RARS_HOST_LINK: begin
        next_state = RARS_HOST_CLEAR;
      end
      RARS_HOST_CLEAR: begin
        next_state = RARS_HOST_READY;
        next_done = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= RARS_HOST_WAIT;
      cnt <= '0;
      pulse_n <= 1'b1;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pulse_n <= next_pulse_n;
      done <= next_done;
    end
  end
  // ********************
  // Memory side
  // ********************
  // Link written first, hold cleared after, so device never sees a gap
  assign link.mem_wr = state == RARS_HOST_LINK || state == RARS_HOST_CLEAR;
  assign link.mem_wdata = state == RARS_HOST_LINK
    ? {24'h000000, new_addr_i}
    : last_word_i & ~(32'h00000001 << `RARS_HOLD_BIT);
  assign link.mem_rdata = 32'h00000000;
  assign link.mem_ack = 1'b0;
  assign link.host_attention_pulse_n = pulse_n;
  assign busy_o = state != RARS_HOST_READY;
  assign done_o = done;
  // Reset length is supplied by the system, two cycles minimum
endmodule : rars_host
`default_nettype wire

// File: rars_checker.sv
// Link checker for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module rars_checker (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic host_attention_pulse_n,
  input wire logic bus_oe,
  input wire logic mem_rd,
  input wire logic [7:0] mem_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  logic [7:0] desc;
  logic dread;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ****************
  // Descriptor track
  // ****************
  // Bench keeps descriptors on 4-word steps from 0x10, pointers at +2
  assign dread = mem_rd && mem_ack && mem_addr >= 8'h10 && !mem_addr[1];
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      desc <= 8'h00;
    end else if (dread) begin
      desc <= mem_addr;
    end
  end
  a_reset_exit_quiet: assert property ($fell(reset_i) |->
    !bus_oe && host_attention_pulse_n) else $error("bus active at reset exit");
  a_settle_no_bus: assert property ($fell(reset_i) |->
    (!bus_oe && !mem_rd)[*8] ##1 (!bus_oe && !mem_rd)[*4])
    else $error("bus used during settle");
  a_host_waits: assert property ($fell(reset_i) |->
    host_attention_pulse_n[*8] ##1 host_attention_pulse_n[*4])
    else $error("request too soon after reset");
  a_pulse_width: assert property ($fell(host_attention_pulse_n) |->
    !host_attention_pulse_n[*2] ##[1:4] $rose(host_attention_pulse_n))
    else $error("request width out of range");
  a_fetch_start: assert property (
    $rose(host_attention_pulse_n) && !bus_oe |->
    ##[1:2] (mem_rd && bus_oe && mem_addr == 8'h00))
    else $error("no fetch after request");
  a_block_order: assert property (
    mem_rd && mem_ack && mem_addr < 8'h03 |=>
    mem_rd && mem_addr == $past(mem_addr) + 8'h01)
    else $error("control block out of order");
  a_addr_stands: assert property (mem_rd && !mem_ack |=>
    mem_rd && $stable(mem_addr)) else $error("read dropped before answer");
  a_hold_repoll: assert property (dread && mem_rdata[30] |=>
    !mem_rd[*7] ##[1:4] (mem_rd && mem_addr == desc))
    else $error("held descriptor not polled");
  a_hold_clear_go: assert property (dread && !mem_rdata[30] |->
    ##[1:4] (mem_rd && mem_addr == desc + 8'h02))
    else $error("cleared descriptor not followed");
endmodule : rars_checker
`default_nettype wire

// File: testbench.sv
// Testbench joining host and device of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rars_cfg.svh"
module testbench;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  logic [`RARS_CNT_W-1:0] pulse_len_i = 4'h3;
  logic release_i = 1'b0;
  logic [7:0] last_addr_i = 8'h14;
  logic [7:0] new_addr_i = 8'h18;
  logic [31:0] last_word_i = 32'h0;
  logic ready_o, frame_start_o, bad_pulse_o, busy_o, done_o, nwr, bad;
  logic [31:0] frame_desc_o;
  logic [31:0] mem [256];
  logic [31:0] descs [$];
  logic [3:0] lens [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'hf};
  int exps [6] = '{2, 2, 2, 5, 5, 5};
  int checks = 0;
  int mismatches = 0;
  int w;
  rars_if host_if();
  rars_if dev_if();
  // ****************
  // Wiring and memory
  // ****************
  // Host ties its answers low, so the bench answers the device
  assign dev_if.host_attention_pulse_n = host_if.host_attention_pulse_n;
  assign dev_if.mem_wr = host_if.mem_wr;
  assign dev_if.mem_wdata = host_if.mem_wdata;
  assign host_if.bus_oe = dev_if.bus_oe;
  assign host_if.mem_rd = dev_if.mem_rd;
  assign host_if.mem_addr = dev_if.mem_addr;
  rars_device rars_device_inst (.clock_i(clock_i), .reset_i(reset_i),
    .link(dev_if), .ready_o(ready_o), .frame_start_o(frame_start_o),
    .frame_desc_o(frame_desc_o), .bad_pulse_o(bad_pulse_o));
  rars_host rars_host_inst (.clock_i(clock_i), .reset_i(reset_i),
    .link(host_if), .start_i(start_i), .pulse_len_i(pulse_len_i),
    .release_i(release_i), .last_addr_i(last_addr_i),
    .new_addr_i(new_addr_i), .last_word_i(last_word_i),
    .busy_o(busy_o), .done_o(done_o));
  rars_checker rars_checker_inst (.clock_i(clock_i), .reset_i(reset_i),
    .host_attention_pulse_n(dev_if.host_attention_pulse_n),
    .bus_oe(dev_if.bus_oe), .mem_rd(dev_if.mem_rd),
    .mem_addr(dev_if.mem_addr), .mem_rdata(dev_if.mem_rdata),
    .mem_ack(dev_if.mem_ack));
  always #12.5 clock_i = ~clock_i;
  // Slow memory: answers every other cycle, garbage data between answers
  always @(negedge clock_i) begin
    if (frame_start_o === 1'b1) descs.push_back(frame_desc_o);
    if (bad_pulse_o === 1'b1) bad = 1'b1;
    if (host_if.mem_wr === 1'b1) begin
      mem[nwr ? last_addr_i : last_addr_i + 8'h02] = host_if.mem_wdata;
      nwr = 1'b1;
    end
    dev_if.mem_ack = dev_if.mem_rd & ~dev_if.mem_ack;
    dev_if.mem_rdata = dev_if.mem_ack ? mem[dev_if.mem_addr] :
      ~mem[dev_if.mem_addr];
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Reset, then let the host request; w ends as the low width seen
  task go(input logic [3:0] len);
    int n;
    reset_i = 1'b1;
    start_i = 1'b0;
    pulse_len_i = len;
    nwr = 1'b0;
    descs.delete();
    repeat (5) @(negedge clock_i);
    chk("oe_in_reset", 32'h0, dev_if.bus_oe);
    reset_i = 1'b0;
    start_i = 1'b1;
    n = 0;
    while (host_if.host_attention_pulse_n !== 1'b0 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    chk("wait_cycles", 32'h1, n >= 12);
    chk("dev_ready", 32'h1, ready_o);
    w = 0;
    while (host_if.host_attention_pulse_n === 1'b0 && w < 20) begin
      @(negedge clock_i);
      w++;
    end
    start_i = 1'b0;
    chk("host_busy", 32'h0, busy_o);
  endtask : go
  task waitf(input int k);
    int n;
    n = 0;
    while (descs.size() < k && n < 300) begin
      @(negedge clock_i);
      n++;
    end
  endtask : waitf
  // ****************
  // Tests
  // ****************
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    mem[3] = 32'h10;
    mem[8'h10] = 32'h0000_1111;
    mem[8'h12] = 32'h14;
    mem[8'h14] = (32'h1 << `RARS_HOLD_BIT) | 32'h2222;
    mem[8'h18] = (32'h1 << `RARS_HOLD_BIT) | 32'h3333;
    dev_if.mem_ack = 1'b0;
    dev_if.mem_rdata = 32'h0;
    bad = 1'b0;
    go(4'h3);
    chk("width", 32'h3, w);
    waitf(1);
    chk("frame0", 32'h0000_1111, descs[0]);
    repeat (60) @(negedge clock_i);
    chk("held", 32'h1, descs.size());
    last_word_i = mem[8'h14];
    release_i = 1'b1;
    @(negedge clock_i);
    release_i = 1'b0;
    w = 0;
    while (done_o !== 1'b1 && w < 100) begin
      @(negedge clock_i);
      w++;
    end
    @(negedge clock_i);
    chk("link", 32'h18, mem[8'h16]);
    chk("clear", 32'h2222, mem[8'h14]);
    waitf(2);
    chk("frame1", 32'h2222, descs[1]);
    repeat (60) @(negedge clock_i);
    chk("held2", 32'h2, descs.size());
    foreach (lens[i]) begin
      go(lens[i]);
      chk("width", exps[i], w);
    end
    chk("bad_pulse", 32'h0, bad);
    results();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    results();
  end
endmodule : testbench
`default_nettype wire
